// File: logic/cefm_pkg.sv
// Purpose: constants and types for the charger event flag and mask bank
// Assumes: register port is driven by the serial bus slave on CLK
// Notes: offsets are byte addresses of 8-bit registers
// Contract
// [RULE1] input overvoltage sets fault bit 7
// [RULE2] battery overcurrent sets fault bit 5
// [RULE3] battery undervoltage event reported on fault bit 4
// [RULE4] thermistor cold/cool/warm/hot entry set bits 3..0
// [RULE5] adc flags at 0x5, timer flags 0x6
// [RULE6] conversion done sets adc bit 7
// [RULE7] comparator alarms set adc bits 6..4
// [RULE8] thermistor open sets adc bit 0
// [RULE9] watchdog expiry sets timer bit 6
// [RULE10] charge safety timer expiry sets timer bit 5
// [RULE11] regulator overcurrent sets timer bit 4
// [RULE12] limit resistor open sets timer bit 3
// [RULE13] button wake timers set timer bits 2, 1
// [RULE14] button reset warning sets timer bit 0
// [RULE15] charger mask at 0x7, one masks
// [RULE16] charger mask bits 6..0 map charger events
// [RULE17] fault mask at 0x8 resets zero
// [RULE18] power good change either way sets flag
// [RULE19] fault mask bits gate matching fault flags
// [RULE20] adc mask resets to 0x71
// [RULE21] flags latch regardless of mask
// [RULE22] event during clearing read survives read
// [RULE23] host reads flags after each interrupt
package cefm_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] OFF_CHG_FLAGS = 8'h03;
    localparam logic [7:0] OFF_FLT_FLAGS = 8'h04;
    localparam logic [7:0] OFF_ADC_FLAGS = 8'h05;
    localparam logic [7:0] OFF_TMR_FLAGS = 8'h06;
    localparam logic [7:0] OFF_CHG_MASK = 8'h07;
    localparam logic [7:0] OFF_FLT_MASK = 8'h08;
    localparam logic [7:0] OFF_ADC_MASK = 8'h09;
    localparam logic [7:0] OFF_TMR_MASK = 8'h0A;
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [7:0] RST_CHG_MASK = 8'h00;
    localparam logic [7:0] RST_FLT_MASK = 8'h00;
    localparam logic [7:0] RST_ADC_MASK = 8'h71;
    localparam logic [7:0] RST_TMR_MASK = 8'h00;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;
    // bits that can ever be set in each flag register
    localparam logic [7:0] VALID_CHG = 8'h7F;
    localparam logic [7:0] VALID_FLT = 8'hBF;
    localparam logic [7:0] VALID_ADC = 8'hF1;
    localparam logic [7:0] VALID_TMR = 8'h7F;
    localparam int BIT_OVP = 7;
    localparam int BIT_OCP = 5;
    localparam int BIT_UVLO = 4;
    localparam int BIT_ADC_READY = 7;
    localparam int BIT_TS_OPEN = 0;
    localparam int BIT_WDOG = 6;
    localparam int BIT_PGOOD = 0;
    localparam int SETTLE_CYCLES = 3;

    typedef struct packed {
        logic const_voltage;
        logic charge_done;
        logic input_limit;
        logic system_droop;
        logic input_droop;
        logic thermal_reg;
        logic input_power_good;
        logic input_overvoltage;
        logic battery_overcurrent;
        logic battery_undervoltage;
        logic therm_cold;
        logic therm_cool;
        logic therm_warm;
        logic therm_hot;
        logic adc_ready;
        logic comparator_one;
        logic comparator_two;
        logic comparator_three;
        logic therm_open;
        logic watchdog_expired;
        logic charge_timer_expired;
        logic regulator_overcurrent;
        logic limit_resistor_open;
        logic button_wake_first;
        logic button_wake_second;
        logic button_reset_warning;
    } cefm_evt_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic rd;
        logic wr;
        logic [DATA_W-1:0] wdata;
    } cefm_req_t;
endpackage

// File: logic/cefm_sync.sv
// Purpose: two-flop synchroniser for a vector of levels
// Assumes: each bit is a level held longer than one CLK period
// Notes: only the second stage leaves this module
`timescale 1ns/10ps
module cefm_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= d;
            sync_ff <= meta_ff;
        end
    end

    assign q = sync_ff;
endmodule

// File: logic/cefm_flags.sv
// Purpose: one clear-on-read sticky flag register
// Assumes: set is a per-bit one-cycle pulse, clr a one-cycle read pulse
// Notes: bits outside VALID never set
`timescale 1ns/10ps
module cefm_flags #(
    parameter int W = 8,
    parameter logic [W-1:0] VALID = '1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] set,
    input wire logic clr,
    output logic [W-1:0] flags
);
    logic [W-1:0] flags_ff;
    logic [W-1:0] nxt_flags;

    always_comb begin
        // a set arriving with the clearing read wins
        nxt_flags = ((clr ? '0 : flags_ff) | set) & VALID; // RULE22
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flags_ff <= RST_VAL;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    assign flags = flags_ff;
endmodule

// File: logic/cefm_top.sv
// Purpose: event flag and interrupt mask bank of the charger
// Assumes: EVT levels come from analog/timer logic outside CLK domain
// Notes: read data appears one cycle after REQ.rd; INT_REQ active high
`timescale 1ns/10ps
module cefm_top (
    input wire logic CLK,
    input wire logic RST,
    input wire cefm_pkg::cefm_evt_t EVT,
    input wire cefm_pkg::cefm_req_t REQ,
    output logic [cefm_pkg::DATA_W-1:0] REG_RDATA,
    output logic INT_REQ
);
    import cefm_pkg::*;

    localparam int EW = $bits(cefm_evt_t);

    cefm_evt_t evt_s;
    cefm_evt_t evt_prev_ff;
    cefm_evt_t rise;
    logic [1:0] settle_ff;
    logic armed_ff;
    logic pgood_change;

    logic [7:0] chg_set;
    logic [7:0] flt_set;
    logic [7:0] adc_set;
    logic [7:0] tmr_set;
    logic [7:0] chg_flags;
    logic [7:0] flt_flags;
    logic [7:0] adc_flags;
    logic [7:0] tmr_flags;
    logic rd_chg;
    logic rd_flt;
    logic rd_adc;
    logic rd_tmr;

    logic [7:0] chg_mask_ff;
    logic [7:0] flt_mask_ff;
    logic [7:0] adc_mask_ff;
    logic [7:0] tmr_mask_ff;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic int_ff;
    logic nxt_int;

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0] off);
        hit = (a == off);
    endfunction

    // pin side: synchronise every event level
    cefm_sync #(
        .W(EW)
    ) u_sync (
        .clk(CLK),
        .rst(RST),
        .d(EVT),
        .q(evt_s)
    );

    // edges are ignored until the synchroniser holds real samples
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            settle_ff <= 2'h0;
            armed_ff <= 1'b0;
        end else begin
            if (settle_ff != 2'(SETTLE_CYCLES)) begin
                settle_ff <= settle_ff + 2'h1;
            end
            armed_ff <= (settle_ff == 2'(SETTLE_CYCLES));
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            evt_prev_ff <= '0;
        end else begin
            evt_prev_ff <= evt_s;
        end
    end

    always_comb begin
        rise = armed_ff ? (evt_s & ~evt_prev_ff) : '0;
    end

    assign pgood_change = armed_ff &&
        (evt_s.input_power_good != evt_prev_ff.input_power_good); // RULE18

    // charger events; bit 0 is the power good change
    always_comb begin
        chg_set = {1'b0,
                   rise.const_voltage,
                   rise.charge_done,
                   rise.input_limit,
                   rise.system_droop,
                   rise.input_droop,
                   rise.thermal_reg,
                   pgood_change}; // RULE16 RULE18
    end

    // fault events: entries into each condition
    always_comb begin
        flt_set = {rise.input_overvoltage, // RULE1
                   1'b0,
                   rise.battery_overcurrent, // RULE2
                   rise.battery_undervoltage, // RULE3
                   rise.therm_cold,
                   rise.therm_cool,
                   rise.therm_warm,
                   rise.therm_hot}; // RULE4
    end

    always_comb begin
        adc_set = {rise.adc_ready, // RULE6
                   rise.comparator_one,
                   rise.comparator_two,
                   rise.comparator_three, // RULE7
                   3'h0,
                   rise.therm_open}; // RULE8
    end

    always_comb begin
        tmr_set = {1'b0,
                   rise.watchdog_expired, // RULE9
                   rise.charge_timer_expired, // RULE10
                   rise.regulator_overcurrent, // RULE11
                   rise.limit_resistor_open, // RULE12
                   rise.button_wake_first,
                   rise.button_wake_second, // RULE13
                   rise.button_reset_warning}; // RULE14
    end

    // a read of a flag register clears it
    assign rd_chg = REQ.rd && hit(REQ.addr, OFF_CHG_FLAGS);
    assign rd_flt = REQ.rd && hit(REQ.addr, OFF_FLT_FLAGS);
    assign rd_adc = REQ.rd && hit(REQ.addr, OFF_ADC_FLAGS); // RULE5
    assign rd_tmr = REQ.rd && hit(REQ.addr, OFF_TMR_FLAGS); // RULE5

    // flags latch whatever the masks say
    cefm_flags #(
        .W(8),
        .VALID(VALID_CHG),
        .RST_VAL(RST_FLAGS)
    ) u_chg (
        .clk(CLK),
        .rst(RST),
        .set(chg_set), // RULE21
        .clr(rd_chg),
        .flags(chg_flags)
    );

    cefm_flags #(
        .W(8),
        .VALID(VALID_FLT),
        .RST_VAL(RST_FLAGS)
    ) u_flt (
        .clk(CLK),
        .rst(RST),
        .set(flt_set), // RULE21
        .clr(rd_flt),
        .flags(flt_flags)
    );

    cefm_flags #(
        .W(8),
        .VALID(VALID_ADC),
        .RST_VAL(RST_FLAGS)
    ) u_adc (
        .clk(CLK),
        .rst(RST),
        .set(adc_set), // RULE21
        .clr(rd_adc),
        .flags(adc_flags)
    );

    cefm_flags #(
        .W(8),
        .VALID(VALID_TMR),
        .RST_VAL(RST_FLAGS)
    ) u_tmr (
        .clk(CLK),
        .rst(RST),
        .set(tmr_set), // RULE21
        .clr(rd_tmr),
        .flags(tmr_flags)
    );

    // mask registers, one means masked
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            chg_mask_ff <= RST_CHG_MASK; // RULE15
            flt_mask_ff <= RST_FLT_MASK; // RULE17
            adc_mask_ff <= RST_ADC_MASK; // RULE20
            tmr_mask_ff <= RST_TMR_MASK;
        end else if (REQ.wr) begin
            if (hit(REQ.addr, OFF_CHG_MASK)) begin
                chg_mask_ff <= REQ.wdata; // RULE15
            end
            if (hit(REQ.addr, OFF_FLT_MASK)) begin
                flt_mask_ff <= REQ.wdata; // RULE17
            end
            if (hit(REQ.addr, OFF_ADC_MASK)) begin
                adc_mask_ff <= REQ.wdata;
            end
            if (hit(REQ.addr, OFF_TMR_MASK)) begin
                tmr_mask_ff <= REQ.wdata;
            end
        end
    end

    // read mux; data shows the value before the clear
    always_comb begin
        nxt_rdata = rdata_ff;
        if (REQ.rd) begin
            unique case (REQ.addr)
                OFF_CHG_FLAGS: nxt_rdata = chg_flags;
                OFF_FLT_FLAGS: nxt_rdata = flt_flags;
                OFF_ADC_FLAGS: nxt_rdata = adc_flags;
                OFF_TMR_FLAGS: nxt_rdata = tmr_flags;
                OFF_CHG_MASK: nxt_rdata = chg_mask_ff;
                OFF_FLT_MASK: nxt_rdata = flt_mask_ff;
                OFF_ADC_MASK: nxt_rdata = adc_mask_ff;
                OFF_TMR_MASK: nxt_rdata = tmr_mask_ff;
                default: nxt_rdata = RD_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rdata_ff <= RD_UNMAPPED;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // interrupt request: any latched flag whose mask bit is zero
    always_comb begin
        nxt_int = |(chg_flags & ~chg_mask_ff) // RULE15 RULE16
                | |(flt_flags & ~flt_mask_ff) // RULE19
                | |(adc_flags & ~adc_mask_ff)
                | |(tmr_flags & ~tmr_mask_ff); // RULE23
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            int_ff <= 1'b0;
        end else begin
            int_ff <= nxt_int;
        end
    end

    assign REG_RDATA = rdata_ff;
    assign INT_REQ = int_ff;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    sequence s_ovp_entry;
        armed_ff && evt_s.input_overvoltage && !evt_prev_ff.input_overvoltage;
    endsequence

    sequence s_read_adc;
        REQ.rd && REQ.addr == OFF_ADC_FLAGS;
    endsequence

    a_ovp_flag_set: assert property ( // RULE1
        s_ovp_entry |=> flt_flags[BIT_OVP]
            ##1 (flt_flags[BIT_OVP] || $past(rd_flt)))
        else $error("overvoltage entry did not latch");
    a_ocp_read_clear: assert property ( // RULE2
        rd_flt && !flt_set[BIT_OCP] |=> !flt_flags[BIT_OCP])
        else $error("overcurrent flag not cleared by read");
    a_adc_read_data: assert property ( // RULE5
        s_read_adc |=> REG_RDATA == $past(adc_flags)
            && (!adc_flags[BIT_ADC_READY] || $past(adc_set[BIT_ADC_READY])))
        else $error("adc flag read wrong");
    a_reserved_zero: assert property ( // RULE8
        adc_flags[3:1] == 3'h0 && !flt_flags[6] && !tmr_flags[7])
        else $error("reserved flag bit set");
    a_wdog_set_wins: assert property ( // RULE22
        rd_tmr && tmr_set[BIT_WDOG] |=> tmr_flags[BIT_WDOG])
        else $error("watchdog event lost on read");
    a_pgood_change: assert property ( // RULE18
        armed_ff && $changed(evt_s.input_power_good)
            |=> chg_flags[BIT_PGOOD])
        else $error("power good change not flagged");
    a_masked_latch: assert property ( // RULE21
        adc_mask_ff[BIT_TS_OPEN] && adc_set[BIT_TS_OPEN]
            |=> adc_flags[BIT_TS_OPEN])
        else $error("masked flag did not latch");
    a_mask_write: assert property ( // RULE15
        REQ.wr && REQ.addr == OFF_CHG_MASK |=> chg_mask_ff == $past(REQ.wdata))
        else $error("charger mask write lost");
    a_fault_mask_gate: assert property ( // RULE19
        (flt_flags & ~flt_mask_ff) != 8'h00 |=> INT_REQ)
        else $error("unmasked fault gave no interrupt");
    a_int_quiet: assert property ( // RULE16
        !nxt_int [*2] |-> ##1 !INT_REQ)
        else $error("interrupt with all flags masked");
    a_adc_mask_reset: assert property ( // RULE20
        $fell(RST) |-> adc_mask_ff == RST_ADC_MASK && flt_mask_ff == 8'h00)
        else $error("mask reset value wrong");

    sequence s_flt_read;
        rd_flt && flt_set == 8'h00;
    endsequence

    a_ovp_flag_hold: assert property ( // RULE1
        flt_flags[BIT_OVP] && !rd_flt |=> flt_flags[BIT_OVP])
        else $error("overvoltage flag dropped without a read");
    a_uvlo_latch: assert property ( // RULE3
        rise.battery_undervoltage |=> flt_flags[BIT_UVLO])
        else $error("undervoltage entry did not latch");
    a_therm_latch: assert property ( // RULE4
        flt_set[3:0] != 4'h0
            |=> (flt_flags[3:0] & $past(flt_set[3:0])) == $past(flt_set[3:0]))
        else $error("thermistor region entry did not latch");
    a_flt_read_clear: assert property ( // RULE2 RULE4
        s_flt_read |=> flt_flags == 8'h00)
        else $error("fault flags not cleared by read");
    a_adc_ready_set: assert property ( // RULE6
        adc_set[BIT_ADC_READY] |=> adc_flags[BIT_ADC_READY])
        else $error("conversion done did not latch");
    a_comp_latch: assert property ( // RULE7
        adc_set[6:4] != 3'h0
            |=> (adc_flags[6:4] & $past(adc_set[6:4])) == $past(adc_set[6:4]))
        else $error("comparator alarm did not latch");
    a_timer_latch: assert property ( // RULE10 RULE11 RULE12 RULE13 RULE14
        tmr_set != 8'h00 |=> (tmr_flags & $past(tmr_set)) == $past(tmr_set))
        else $error("timer fault did not latch");
    a_flt_mask_write: assert property ( // RULE17
        REQ.wr && REQ.addr == OFF_FLT_MASK
            |=> flt_mask_ff == $past(REQ.wdata))
        else $error("fault mask write lost");
    a_rdata_stands: assert property ( // RULE5
        !REQ.rd |=> $stable(REG_RDATA))
        else $error("read data moved without a read");
endmodule

// File: tb/cefm_host.sv
// Purpose: host model driving the register port of the flag/mask bank
// Assumes: one request per call, requests start on a rising edge
// Notes: idle address and data carry the inverse of the last request
`timescale 1ns/10ps
module cefm_host (
    input wire logic clk,
    input wire logic rst,
    output cefm_pkg::cefm_req_t req,
    input wire logic [cefm_pkg::DATA_W-1:0] rdata
);
    import cefm_pkg::*;

    initial begin
        req = '{addr: 8'hFF, rd: 1'b0, wr: 1'b0, wdata: 8'hFF};
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        while (rst) begin
            @(posedge clk);
        end
        @(posedge clk);
        req <= '{addr: a, rd: 1'b0, wr: 1'b1, wdata: d};
        @(posedge clk);
        req <= '{addr: ~a, rd: 1'b0, wr: 1'b0, wdata: ~d};
    endtask

    // a read hands back the latched flags and re-arms them
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        while (rst) begin
            @(posedge clk);
        end
        @(posedge clk);
        req <= '{addr: a, rd: 1'b1, wr: 1'b0, wdata: 8'hA5};
        @(posedge clk);
        req <= '{addr: ~a, rd: 1'b0, wr: 1'b0, wdata: 8'h5A};
        @(negedge clk);
        d = rdata;
    endtask
endmodule

// File: tb/tb.sv
// Purpose: self-checking bench for the charger flag and mask bank
// Assumes: event levels held well beyond the two-flop synchroniser
// Notes: one row per event source, awkward cases written out after
`timescale 1ns/10ps
module tb;
    import cefm_pkg::*;

    typedef struct packed {
        logic [7:0] addr;
        logic [2:0] bitn;
        logic irq;
    } cefm_row_t;

    logic CLK = 1'b0;
    logic RST = 1'b1;
    cefm_evt_t evt = '0;
    cefm_req_t req;
    logic [7:0] rdata;
    logic irq;
    int miscompares = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [7:0] r1, r2, r3;
    cefm_row_t rows [26];

    always #2.5 CLK = ~CLK;

    cefm_top dut_u (.CLK(CLK), .RST(RST), .EVT(evt), .REQ(req),
        .REG_RDATA(rdata), .INT_REQ(irq));
    cefm_host host_u (.clk(CLK), .rst(RST), .req(req), .rdata(rdata));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // move one event level, then let sync, latch and interrupt settle
    task automatic ev(input int idx, input logic v);
        @(posedge CLK);
        evt[idx] <= v;
        repeat (6) @(posedge CLK);
        @(negedge CLK);
    endtask

    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            miscompares++;
            final_report();
        end
    end

    initial begin
        rows = '{
            '{8'h03, 3'd6, 1'b1}, '{8'h03, 3'd5, 1'b1},
            '{8'h03, 3'd4, 1'b1}, '{8'h03, 3'd3, 1'b1},
            '{8'h03, 3'd2, 1'b1}, '{8'h03, 3'd1, 1'b1},
            '{8'h03, 3'd0, 1'b1}, '{8'h04, 3'd7, 1'b1},
            '{8'h04, 3'd5, 1'b1}, '{8'h04, 3'd4, 1'b1},
            '{8'h04, 3'd3, 1'b1}, '{8'h04, 3'd2, 1'b1},
            '{8'h04, 3'd1, 1'b1}, '{8'h04, 3'd0, 1'b1},
            '{8'h05, 3'd7, 1'b1}, '{8'h05, 3'd6, 1'b0},
            '{8'h05, 3'd5, 1'b0}, '{8'h05, 3'd4, 1'b0},
            '{8'h05, 3'd0, 1'b0}, '{8'h06, 3'd6, 1'b1},
            '{8'h06, 3'd5, 1'b1}, '{8'h06, 3'd4, 1'b1},
            '{8'h06, 3'd3, 1'b1}, '{8'h06, 3'd2, 1'b1},
            '{8'h06, 3'd1, 1'b1}, '{8'h06, 3'd0, 1'b1}};
        repeat (5) @(posedge CLK);
        @(negedge CLK);
        chk(rdata, 8'h00);
        chk({7'h00, irq}, 8'h00);
        @(posedge CLK);
        RST <= 1'b0;
        repeat (8) @(posedge CLK);
        host_u.rd(8'h05, r1);
        chk(r1, 8'h00);
        host_u.rd(8'h06, r1);
        chk(r1, 8'h00);
        host_u.rd(8'h07, r1);
        chk(r1, 8'h00);
        host_u.rd(8'h08, r1);
        chk(r1, 8'h00);
        host_u.rd(8'h09, r1);
        chk(r1, 8'h71);
        host_u.rd(8'h20, r1);
        chk(r1, 8'h00);
        host_u.rd(8'h0A, r1);
        chk(r1, 8'h00);
        host_u.wr(8'h06, 8'hFF);
        host_u.rd(8'h06, r1);
        chk(r1, 8'h00);

        // each source: latch, interrupt except the four adc sources masked at reset, clear on read, no flag on fall except power good
        for (int i = 0; i < 26; i++) begin
            ev(25 - i, 1'b1);
            chk({7'h00, irq}, {7'h00, rows[i].irq});
            host_u.rd(rows[i].addr, r1);
            chk(r1, 8'h01 << rows[i].bitn);
            repeat (2) @(negedge CLK);
            chk({7'h00, irq}, 8'h00);
            host_u.rd(rows[i].addr, r1);
            chk(r1, 8'h00);
            ev(25 - i, 1'b0);
            host_u.rd(rows[i].addr, r1);
            chk(r1, (i == 6) ? 8'h01 : 8'h00);
        end

        // masks block the request but not the latching
        host_u.wr(8'h08, 8'hFF);
        host_u.wr(8'h07, 8'h7F);
        host_u.rd(8'h07, r1);
        chk(r1, 8'h7F);
        ev(18, 1'b1);
        chk({7'h00, irq}, 8'h00);
        ev(25, 1'b1);
        chk({7'h00, irq}, 8'h00);
        host_u.wr(8'h08, 8'h00);
        repeat (2) @(negedge CLK);
        chk({7'h00, irq}, 8'h01);
        host_u.rd(8'h04, r1);
        chk(r1, 8'h80);
        host_u.rd(8'h03, r1);
        chk(r1, 8'h40);
        ev(18, 1'b0);
        ev(25, 1'b0);
        host_u.wr(8'h07, 8'h00);

        // timer mask blocks the watchdog request, flag still latches
        host_u.wr(8'h0A, 8'h40);
        ev(6, 1'b1);
        chk({7'h00, irq}, 8'h00);
        host_u.wr(8'h0A, 8'h00);
        repeat (2) @(negedge CLK);
        chk({7'h00, irq}, 8'h01);
        host_u.rd(8'h06, r1);
        chk(r1, 8'h40);
        ev(6, 1'b0);

        // a read landing near the latch edge must not lose the event
        for (int k = 0; k < 5; k++) begin
            @(posedge CLK);
            evt[6] <= 1'b1;
            repeat (k) @(posedge CLK);
            host_u.rd(8'h06, r1);
            host_u.rd(8'h06, r2);
            repeat (6) @(posedge CLK);
            host_u.rd(8'h06, r3);
            chk(r1 | r2 | r3, 8'h40);
            ev(6, 1'b0);
        end

        // second reset with a level still high and a mask rewritten
        host_u.wr(8'h09, 8'h00);
        host_u.rd(8'h09, r1);
        chk(r1, 8'h00);
        ev(6, 1'b1);
        @(posedge CLK);
        RST <= 1'b1;
        repeat (2) @(posedge CLK);
        @(negedge CLK);
        chk({7'h00, irq}, 8'h00);
        chk(rdata, 8'h00);
        @(posedge CLK);
        RST <= 1'b0;
        repeat (8) @(posedge CLK);
        host_u.rd(8'h06, r1);
        chk(r1, 8'h00);
        host_u.rd(8'h09, r1);
        chk(r1, 8'h71);
        final_report();
    end
endmodule
